// file: sss_pkg.sv
// Purpose: constants and types shared by the sun sensor status word block
// Assumes: 32-bit classic Wishbone register bus, 8-bit byte address
// Notes:   all offsets are byte addresses of aligned words
package sss_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] SSS_OFS_CTRL   = 8'h00;
  localparam logic [7:0] SSS_OFS_ANGLE  = 8'h04;
  localparam logic [7:0] SSS_OFS_EDGE0  = 8'h08; // six words, 8'h08..8'h1c
  localparam logic [7:0] SSS_OFS_IRQST  = 8'h20;
  localparam logic [7:0] SSS_OFS_IRQMSK = 8'h24;
  localparam logic [7:0] SSS_OFS_STATE  = 8'h28;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int SSS_CTL_INVALID = 0;
  localparam int SSS_CTL_SLEW    = 1;
  localparam int SSS_CTL_SECTOR  = 2;
  localparam int SSS_CTL_ALTSEL  = 3;
  localparam int SSS_CTL_RATE_LO = 4; // two bits, 4..5
  localparam int SSS_CTL_SCANCW  = 6;
  localparam int SSS_CTL_PLANAR  = 7;
  localparam int SSS_CTL_TGT_LO  = 8; // three bits, 8..10
  localparam int SSS_CTL_WIDTH   = 11;
  localparam logic [SSS_CTL_WIDTH-1:0] SSS_CTL_RESET = 11'h000;

  // ----------------------------------------------------------------
  // angle / edge fields, status word
  // ----------------------------------------------------------------
  localparam int SSS_POS_BITS   = 9;
  localparam int SSS_FIELD_BITS = 10; // direction bit on top of the position
  localparam int SSS_EDGE_NUM   = 6;
  localparam int SSS_WORD_BITS  = 80;
  localparam logic [2:0] SSS_MAX_TARGETS = 3'h3;
  localparam logic [SSS_FIELD_BITS-1:0] SSS_FIELD_RESET = 10'h000;

  // edge index: 0 first loss, 1 first acquire, 2/3 second, 4/5 third
  localparam int SSS_E1_LOSS = 0;
  localparam int SSS_E1_ACQ  = 1;
  localparam int SSS_E2_LOSS = 2;
  localparam int SSS_E2_ACQ  = 3;
  localparam int SSS_E3_LOSS = 4;
  localparam int SSS_E3_ACQ  = 5;

  // ----------------------------------------------------------------
  // interrupt status bits
  // ----------------------------------------------------------------
  localparam int SSS_IRQ_DONE  = 0; // word fully shifted out
  localparam int SSS_IRQ_OVFL  = 1; // word latched with target overflow
  localparam int SSS_IRQ_WIDTH = 2;
  localparam logic [SSS_IRQ_WIDTH-1:0] SSS_IRQ_RESET = 2'h0;

  localparam logic [6:0] SSS_CNT_RESET = 7'h00;

  typedef enum logic [0:0] {
    SSS_IDLE  = 1'b0,
    SSS_SHIFT = 1'b1
  } sss_state_t;

endpackage

// file: sss_status_word.sv
// Purpose: assembles the 80-bit sun sensor status word and shifts it out to telemetry
// Assumes: telemetry gate and bit clock are asynchronous pins, sampled on mclk
// Notes:   software loads angle, edges and control over classic Wishbone
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// (RQ1) Bit 1 carries the angle direction (1 clockwise) and bits 2-10 the 9-bit angle, MSB first.
// (RQ2) Bit 12 flags fresh data only in planar mode, and bit 20 reports planar mode.
// (RQ3) Bits 11, 13 and 14 flag invalid data, more than three targets and slew enable.
// (RQ4) Bit 15 shows sector scan mode and bit 16 shows the alternate sun sensor selected.
// (RQ5) Bits 17-18 carry the scan drive rate code 0 to 3, fastest clock at code 0.
// (RQ6) Bit 19 is one for clockwise scanning and zero for counterclockwise.
// (RQ7) Bits 21-80 hold six 10-bit edge fields, direction plus hybrid position in planar mode, else plain counts.
// (RQ8) Each 9-bit position is sent as six binary upper bits and three Gray-coded lower bits.
// (RQ9) The word leaves serially with bit 1 first.
// (RQ10) From bit 21 up the edges run third loss, third acquire, second, then first target.
module sss_status_word
  import sss_pkg::*;
(
  input  wire logic        mclk,      // system clock, 40 MHz
  input  wire logic        rstn,      // asynchronous reset, active low
  input  wire logic        wb_cyc_i,  // bus cycle
  input  wire logic        wb_stb_i,  // strobe
  input  wire logic        wb_we_i,   // write enable
  input  wire logic [7:0]  wb_adr_i,  // byte address
  input  wire logic [3:0]  wb_sel_i,  // byte lanes
  input  wire logic [31:0] wb_dat_i,  // write data
  output logic      [31:0] wb_dat_o,  // read data
  output logic             wb_ack_o,  // acknowledge
  output logic             irq,       // level interrupt, active high
  input  wire logic        tlmGate,   // telemetry readout gate pin, active high
  input  wire logic        tlmClk,    // telemetry bit clock pin
  output logic             tlmData    // serial status word
);
  import sss_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // upper bits stay binary, the low three count in Gray so one step flips one bit
  function automatic logic [SSS_POS_BITS-1:0] hybridCode(input logic [SSS_POS_BITS-1:0] pos);
    hybridCode = {pos[8:3], pos[2], pos[2] ^ pos[1], pos[1] ^ pos[0]}; // RQ8
  endfunction

  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = wr[i*8 +: 8];
      end
    end
    laneMerge = res;
  endfunction

  // more targets than the six edge fields can hold
  function automatic logic targetOverflow(input logic [SSS_CTL_WIDTH-1:0] c);
    targetOverflow = c[SSS_CTL_TGT_LO +: 3] > SSS_MAX_TARGETS; // RQ3
  endfunction

  // word-aligned hit in the six edge registers
  function automatic logic edgeHit(input logic [7:0] adr);
    edgeHit = adr >= SSS_OFS_EDGE0 && adr < SSS_OFS_IRQST && adr[1:0] == 2'h0;
  endfunction

  // edge register index, one word per edge
  function automatic logic [2:0] edgeIdx(input logic [7:0] adr);
    logic [7:0] ofs;
    ofs     = adr - SSS_OFS_EDGE0;
    edgeIdx = ofs[4:2];
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [SSS_CTL_WIDTH-1:0]  ctrl_r,    ctrl_nxt;
  logic [SSS_FIELD_BITS-1:0] angle_r,   angle_nxt;
  logic [SSS_FIELD_BITS-1:0] edge_r   [SSS_EDGE_NUM];
  logic [SSS_FIELD_BITS-1:0] edge_nxt [SSS_EDGE_NUM];
  logic                      newData_r, newData_nxt;
  logic [SSS_IRQ_WIDTH-1:0]  irqSt_r,   irqSt_nxt;
  logic [SSS_IRQ_WIDTH-1:0]  irqMsk_r,  irqMsk_nxt;
  logic                      ack_r,     ack_nxt;
  logic [31:0]               rdat_r,    rdat_nxt;
  logic                      irq_r,     irq_nxt;
  sss_state_t                state_r,   state_nxt;
  logic [SSS_WORD_BITS-1:0]  shift_r,   shift_nxt;
  logic [6:0]                bitCnt_r,  bitCnt_nxt;
  logic                      txd_r,     txd_nxt;
  logic [2:0]                gateSync_r;
  logic [2:0]                clkSync_r;

  logic                      planar;
  logic [SSS_WORD_BITS-1:0]  word;
  logic                      wrHit;
  logic                      gateRise;
  logic                      clkRise;
  logic                      gateOn;
  logic [31:0]               wrCtrl;
  logic [31:0]               wrData;

  // ----------------------------------------------------------------
  // pin synchronisers, stage 0 is read only by stage 1
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      gateSync_r <= 3'h0;
      clkSync_r  <= 3'h0;
    end else begin
      gateSync_r <= {gateSync_r[1:0], tlmGate};
      clkSync_r  <= {clkSync_r[1:0], tlmClk};
    end
  end

  assign gateOn   = gateSync_r[1];
  assign gateRise = gateSync_r[1] & ~gateSync_r[2];
  assign clkRise  = clkSync_r[1] & ~clkSync_r[2];

  // ----------------------------------------------------------------
  // status word assembly, vector MSB is word bit 1
  // ----------------------------------------------------------------
  function automatic logic [SSS_FIELD_BITS-1:0] edgeField(input logic [SSS_FIELD_BITS-1:0] raw,
                                                          input logic pl);
    if (pl) begin
      edgeField = {raw[SSS_FIELD_BITS-1], hybridCode(raw[SSS_POS_BITS-1:0])}; // RQ7
    end else begin
      edgeField = raw; // RQ7
    end
  endfunction

  assign planar = ctrl_r[SSS_CTL_PLANAR];

  always_comb begin
    word = {angle_r[SSS_FIELD_BITS-1],                    // RQ1
            hybridCode(angle_r[SSS_POS_BITS-1:0]),        // RQ1 RQ8
            ctrl_r[SSS_CTL_INVALID],                      // RQ3
            newData_r & planar,                           // RQ2
            targetOverflow(ctrl_r),                       // RQ3
            ctrl_r[SSS_CTL_SLEW],                         // RQ3
            ctrl_r[SSS_CTL_SECTOR],                       // RQ4
            ctrl_r[SSS_CTL_ALTSEL],                       // RQ4
            ctrl_r[SSS_CTL_RATE_LO +: 2],                 // RQ5
            ctrl_r[SSS_CTL_SCANCW],                       // RQ6
            planar,                                       // RQ2
            edgeField(edge_r[SSS_E3_LOSS], planar),       // RQ10
            edgeField(edge_r[SSS_E3_ACQ],  planar),       // RQ10
            edgeField(edge_r[SSS_E2_LOSS], planar),       // RQ10
            edgeField(edge_r[SSS_E2_ACQ],  planar),       // RQ10
            edgeField(edge_r[SSS_E1_LOSS], planar),       // RQ10
            edgeField(edge_r[SSS_E1_ACQ],  planar)};      // RQ10
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // writes take effect on the edge where the master sees ack high
  assign wrHit  = wb_cyc_i & wb_stb_i & wb_we_i & ack_r;
  // control keeps unselected lanes, the other registers clear them
  assign wrCtrl = laneMerge({21'h0, ctrl_r}, wb_dat_i, wb_sel_i);
  assign wrData = laneMerge(32'h0, wb_dat_i, wb_sel_i);

  always_comb begin
    logic [SSS_IRQ_WIDTH-1:0] evt;
    evt         = '0;
    ctrl_nxt    = ctrl_r;
    angle_nxt   = angle_r;
    edge_nxt    = edge_r;
    newData_nxt = newData_r;
    irqMsk_nxt  = irqMsk_r;
    state_nxt   = state_r;
    shift_nxt   = shift_r;
    bitCnt_nxt  = bitCnt_r;
    txd_nxt     = txd_r;
    ack_nxt     = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt    = rdat_r;

    // serial readout
    case (state_r)
      SSS_IDLE: begin
        if (gateRise) begin
          txd_nxt     = word[SSS_WORD_BITS-1]; // RQ9
          shift_nxt   = {word[SSS_WORD_BITS-2:0], 1'b0};
          bitCnt_nxt  = 7'(SSS_WORD_BITS - 1);
          newData_nxt = 1'b0;
          evt[SSS_IRQ_OVFL] = targetOverflow(ctrl_r); // RQ3
          state_nxt   = SSS_SHIFT;
        end
      end
      SSS_SHIFT: begin
        // the 80th rise carries no bit, it only closes the word
        if (!gateOn) begin
          // readout cut short: abandon the rest of the word
          state_nxt = SSS_IDLE;
        end else if (clkRise) begin
          if (bitCnt_r == SSS_CNT_RESET) begin
            evt[SSS_IRQ_DONE] = 1'b1;
            state_nxt         = SSS_IDLE;
          end else begin
            txd_nxt    = shift_r[SSS_WORD_BITS-1]; // RQ9
            shift_nxt  = {shift_r[SSS_WORD_BITS-2:0], 1'b0};
            bitCnt_nxt = bitCnt_r - 7'h01;
          end
        end
      end
      default: begin
        state_nxt = SSS_IDLE;
      end
    endcase

    // register writes
    // unmapped and read-only addresses drop the write but are still acked
    if (wrHit) begin
      case (wb_adr_i)
        SSS_OFS_CTRL:   ctrl_nxt   = wrCtrl[SSS_CTL_WIDTH-1:0];
        SSS_OFS_ANGLE: begin
          angle_nxt   = wrData[SSS_FIELD_BITS-1:0];
          newData_nxt = 1'b1; // RQ2
        end
        SSS_OFS_IRQMSK: irqMsk_nxt = wrData[SSS_IRQ_WIDTH-1:0];
        default: begin
          if (edgeHit(wb_adr_i)) begin
            edge_nxt[edgeIdx(wb_adr_i)] = wrData[SSS_FIELD_BITS-1:0]; // RQ7
          end
        end
      endcase
    end

    // sticky status: a new event wins over a write-one clear
    irqSt_nxt = irqSt_r;
    if (wrHit && wb_adr_i == SSS_OFS_IRQST) begin
      irqSt_nxt = irqSt_r & ~wrData[SSS_IRQ_WIDTH-1:0];
    end
    irqSt_nxt = irqSt_nxt | evt;
    // irq follows the next status so it moves in step with the sticky bits
    irq_nxt   = |(irqSt_nxt & irqMsk_nxt);

    // read data, unmapped addresses read zero
    // write cycles leave the last read data standing
    if (ack_nxt && !wb_we_i) begin
      rdat_nxt = 32'h0;
      case (wb_adr_i)
        SSS_OFS_CTRL:   rdat_nxt[SSS_CTL_WIDTH-1:0]  = ctrl_r;
        SSS_OFS_ANGLE:  rdat_nxt[SSS_FIELD_BITS-1:0] = angle_r;
        SSS_OFS_IRQST:  rdat_nxt[SSS_IRQ_WIDTH-1:0]  = irqSt_r;
        SSS_OFS_IRQMSK: rdat_nxt[SSS_IRQ_WIDTH-1:0]  = irqMsk_r;
        // readout progress, so software can poll instead of waiting for irq
        SSS_OFS_STATE:  rdat_nxt[8:0] = {newData_r, state_r == SSS_SHIFT, bitCnt_r};
        default: begin
          if (edgeHit(wb_adr_i)) begin
            rdat_nxt[SSS_FIELD_BITS-1:0] = edge_r[edgeIdx(wb_adr_i)];
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r    <= SSS_CTL_RESET;
      angle_r   <= SSS_FIELD_RESET;
      for (int i = 0; i < SSS_EDGE_NUM; i++) begin
        edge_r[i] <= SSS_FIELD_RESET;
      end
      newData_r <= 1'b0;
      irqSt_r   <= SSS_IRQ_RESET;
      irqMsk_r  <= SSS_IRQ_RESET;
      ack_r     <= 1'b0;
      rdat_r    <= 32'h0;
      irq_r     <= 1'b0;
      state_r   <= SSS_IDLE;
      shift_r   <= '0;
      bitCnt_r  <= SSS_CNT_RESET;
      txd_r     <= 1'b0;
    end else begin
      ctrl_r    <= ctrl_nxt;
      angle_r   <= angle_nxt;
      edge_r    <= edge_nxt;
      newData_r <= newData_nxt;
      irqSt_r   <= irqSt_nxt;
      irqMsk_r  <= irqMsk_nxt;
      ack_r     <= ack_nxt;
      rdat_r    <= rdat_nxt;
      irq_r     <= irq_nxt;
      state_r   <= state_nxt;
      shift_r   <= shift_nxt;
      bitCnt_r  <= bitCnt_nxt;
      txd_r     <= txd_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
  assign irq      = irq_r;
  assign tlmData  = txd_r;

endmodule // sss_status_word

`default_nettype wire

// file: sss_status_word_props.sv
// Purpose: port-level checks of the sun sensor status word block
// Assumes: one clock domain, telemetry pins held at least 3 mclk between edges
// Notes:   pin age counter tracks time since the last gate or bit clock edge
`timescale 1ns/100ps
`default_nettype none
module sss_status_word_props
  import sss_pkg::*;
(
  input wire logic        mclk,     // system clock
  input wire logic        rstn,     // async reset, active low
  input wire logic        wb_cyc_i, // bus cycle
  input wire logic        wb_stb_i, // strobe
  input wire logic        wb_we_i,  // write enable
  input wire logic [7:0]  wb_adr_i, // byte address
  input wire logic [3:0]  wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic        wb_ack_o, // acknowledge
  input wire logic        irq,      // level interrupt
  input wire logic        tlmGate,  // readout gate pin
  input wire logic        tlmClk,   // bit clock pin
  input wire logic        tlmData   // serial word
);
  // ----------------------------------------------------------------
  // pin age, saturates so long idle stretches stay harmless
  // ----------------------------------------------------------------
  logic [3:0] quietCnt_r, quietCnt_nxt;
  logic       clkSeen_r, gateSeen_r;
  always_comb begin
    quietCnt_nxt = quietCnt_r + {3'h0, quietCnt_r != 4'hf};
    if (tlmClk != clkSeen_r || tlmGate != gateSeen_r) begin
      quietCnt_nxt = 4'h0;
    end
  end
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      quietCnt_r <= 4'hf;
      clkSeen_r  <= 1'b0;
      gateSeen_r <= 1'b0;
    end else begin
      quietCnt_r <= quietCnt_nxt;
      clkSeen_r  <= tlmClk;
      gateSeen_r <= tlmGate;
    end
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  ack_after_req_a: assert property (reqTaken |=> wb_ack_o)
    else $error("no ack one cycle after request");
  ack_one_wide_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");
  ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h2b |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
    else $error("read data moved outside a read");
  irq_rise_a: assert property ($rose(irq) |-> $past(wb_ack_o) || quietCnt_r < 4'ha)
    else $error("interrupt rose without cause");
  irq_fall_a: assert property ($fell(irq) |-> $past(wb_ack_o && wb_we_i))
    else $error("interrupt fell without a write");
  bit_timing_a: assert property ($changed(tlmData) |-> quietCnt_r inside {[1:6]})
    else $error("serial bit moved off a pin edge");
endmodule // sss_status_word_props
bind sss_status_word sss_status_word_props u_props (.mclk(mclk), .rstn(rstn),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq(irq), .tlmGate(tlmGate), .tlmClk(tlmClk), .tlmData(tlmData));
`default_nettype wire

// file: sss_tlm_receiver.sv
// Purpose: telemetry reader that gates and clocks the status word out
// Assumes: samples each bit at the end of the bit clock low phase, just before the next rising edge
// Notes:   slow selects a longer bit clock half period
`timescale 1ns/100ps
`default_nettype none
module sss_tlm_receiver (
  input  wire logic        mclk,    // system clock
  input  wire logic        start,   // one-cycle readout request
  input  wire logic        slow,    // long half period
  input  wire logic        tlmData, // serial word from the block
  output logic             tlmGate, // readout gate
  output logic             tlmClk,  // bit clock
  output logic      [79:0] word,    // captured word, bit 1 on top
  output logic             busy     // readout running
);
  int h;
  initial begin
    tlmGate = 1'b0;
    tlmClk  = 1'b0;
    word    = 80'h0;
    busy    = 1'b0;
    h       = 4;
    forever begin
      @(posedge mclk);
      if (start) begin
        h = slow ? 9 : 4;
        busy    <= 1'b1;
        tlmGate <= 1'b1;
        repeat (8) @(posedge mclk);
        word <= {word[78:0], tlmData};
        // the 80th rise closes the word, nothing is sampled after it
        for (int k = 0; k < 80; k++) begin
          tlmClk <= 1'b1;
          repeat (h) @(posedge mclk);
          tlmClk <= 1'b0;
          repeat (h) @(posedge mclk);
          if (k < 79) word <= {word[78:0], tlmData};
        end
        tlmGate <= 1'b0;
        busy    <= 1'b0;
      end
    end
  end
endmodule // sss_tlm_receiver
`default_nettype wire

// file: tb_sun_sensor_status_word.sv
// Purpose: self-checking bench for the sun sensor status word block
// Assumes: registers loaded over the bus, word read back by the receiver model
// Notes:   expected word is rebuilt from written values
`timescale 1ns/100ps
`default_nettype none
module tb_sun_sensor_status_word;
  import sss_pkg::*;
  logic        mclk, rstn, wbCyc, wbStb, wbWe, ack, irq, tlmGate, tlmClk, tlmData;
  logic        pStart, pSlow, pBusy, nd, ovf;
  logic [7:0]  wbAdr;
  logic [31:0] wbDat, rdat, q, rnd;
  logic [79:0] pWord;
  logic [10:0] ctl;
  logic [9:0]  ang;
  logic [9:0]  edg [6];
  int          errCount, comparisons, n;
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  sss_status_word DUT (.mclk(mclk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq(irq), .tlmGate(tlmGate), .tlmClk(tlmClk), .tlmData(tlmData));
  sss_tlm_receiver u_rx (.mclk(mclk), .start(pStart), .slow(pSlow), .tlmData(tlmData),
    .tlmGate(tlmGate), .tlmClk(tlmClk), .word(pWord), .busy(pBusy));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [8:0] hyb(input logic [8:0] p);
    return {p[8:3], p[2], p[2] ^ p[1], p[1] ^ p[0]};
  endfunction
  function automatic logic [79:0] model(input logic [10:0] c, input logic [9:0] a,
                                        input logic nw);
    logic [79:0] w;
    int          j;
    w[79:70] = {a[9], hyb(a[8:0])};
    w[69:60] = {c[0], nw & c[7], c[10:8] > SSS_MAX_TARGETS, c[1], c[2], c[3], c[5], c[4],
                c[6], c[7]};
    for (int k = 0; k < 6; k++) begin
      j = 4 - 2 * (k / 2) + k % 2;
      w[59 - 10 * k -: 10] = c[7] ? {edg[j][9], hyb(edg[j][8:0])} : edg[j];
    end
    return w;
  endfunction
  task automatic chk(input logic [79:0] seen, input logic [79:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // called just after a rising edge; returns one idle cycle later
  task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    int t;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= a;
    wbDat <= d;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (ack !== 1'b1 && t < 20);
    if (ack !== 1'b1) begin
      errCount++;
      end_of_test();
    end
    r = rdat;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    @(posedge mclk);
  endtask
  initial begin
    {rstn, wbCyc, wbStb, wbWe, pStart, pSlow, nd} = 7'h0;
    wbAdr = 8'h00;
    wbDat = 32'h0;
    rnd = 32'h4f221583;
    errCount = 0;
    comparisons = 0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    wbx(1'b0, SSS_OFS_CTRL, 32'h0, q);
    chk(80'(q), 80'h0);
    wbx(1'b0, SSS_OFS_STATE, 32'h0, q);
    chk(80'(q), 80'h0);
    wbx(1'b1, 8'h30, 32'hffffffff, q);
    wbx(1'b0, 8'h30, 32'h0, q);
    chk(80'(q), 80'h0);
    for (int i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      ctl = {i[0], rnd[9:8], ~i[0], rnd[6], i[1:0], rnd[3:0]};
      wbx(1'b1, SSS_OFS_CTRL, {21'h0, ctl}, q);
      wbx(1'b1, SSS_OFS_IRQMSK, (i < 3) ? 32'h1 : 32'h2, q);
      // one pass skips the angle write so fresh data must read clear
      if (i != 2) begin
        ang = rnd[20:11];
        nd = 1'b1;
        wbx(1'b1, SSS_OFS_ANGLE, {22'h0, ang}, q);
      end
      for (int k = 0; k < 6; k++) begin
        rnd = lfsr(rnd);
        edg[k] = rnd[9:0];
        wbx(1'b1, SSS_OFS_EDGE0 + 8'(4 * k), {22'h0, edg[k]}, q);
        wbx(1'b0, SSS_OFS_EDGE0 + 8'(4 * k), 32'h0, q);
        chk(80'(q), 80'(edg[k]));
      end
      pSlow <= i[2];
      pStart <= 1'b1;
      @(posedge mclk);
      pStart <= 1'b0;
      repeat (2) @(posedge mclk);
      for (n = 0; pBusy !== 1'b0 && n < 4000; n++) @(posedge mclk);
      if (n >= 4000) begin
        errCount++;
        end_of_test();
      end
      repeat (4) @(posedge mclk);
      chk(pWord, model(ctl, ang, nd));
      nd = 1'b0;
      ovf = ctl[10:8] > SSS_MAX_TARGETS;
      chk(80'(irq), 80'((i < 3) || ovf));
      wbx(1'b0, SSS_OFS_IRQST, 32'h0, q);
      chk(80'(q), {78'h0, ovf, 1'b1});
      wbx(1'b1, SSS_OFS_IRQST, 32'h3, q);
      @(posedge mclk);
      chk(80'(irq), 80'h0);
      wbx(1'b0, SSS_OFS_STATE, 32'h0, q);
      chk(80'(q), 80'h0);
      $display("test %0d done", i);
    end
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    wbx(1'b0, SSS_OFS_CTRL, 32'h0, q);
    chk(80'(q), 80'h0);
    wbx(1'b0, SSS_OFS_ANGLE, 32'h0, q);
    chk(80'(q), 80'h0);
    $display("test reset done");
    end_of_test();
  end
endmodule // tb_sun_sensor_status_word
`default_nettype wire
